// ===== src/adc_calibration_control.sv
// calibration run/hold control, configuration registers and status flags
//
// Functional notes
// [RL1] run bit one runs, zero holds reset
// [RL2] run bit low also resets clock dividers
// [RL3] software clears run before changing settings
// [RL4] run before link enable; link off first
// [RL5] background offset needs background enable
// [RL6] foreground offset needs foreground select
// [RL7] background enable switches continuous calibration
// [RL8] start clears values, foreground runs if selected
// [RL9] park field selects disabled core
// [RL10] park field changes only with link off
// [RL11] offset averaging field, reset six
// [RL12] linearity averaging field, reset one
// [RL13] read-only status code field
// [RL14] halted flag set when stopped, cleared resuming
// [RL15] no background: halted at foreground finish
// [RL16] foreground-complete high after finish or skip
// [RL17] status pin source select
// [RL18] trigger source select software or hardware
// [RL19] flags held zero while run is low
`timescale 1ns/10ps
`default_nettype none
module adc_calibration_control (
    // clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    // register port
    input  wire logic                        regWrite,
    input  wire logic                        regRead,
    input  wire logic [7:0]                  regAddr,
    input  wire logic [7:0]                  regWdata,
    output logic      [7:0]                  regRdata,
    // link state and external events
    input  wire logic                        serial_link_enable,
    input  wire logic                        hardware_trigger_input,
    input  wire logic                        alarm,
    input  wire logic                        bgStopRequest,
    // engine side
    output logic                             engineResetN,
    output logic                             dividerResetN,
    output logic                             calValueClear,
    output calib_ctrl_pkg::engine_ctl_t      engineCtl,
    // pin
    output logic                             status_output_pin
);
    typedef enum logic [2:0] {
        ST_HELD,
        ST_CLEAR,
        ST_WAIT_TRIG,
        ST_FG_RUN,
        ST_BG_RUN,
        ST_IDLE
    } cal_state_t;

    logic [7:0] runCtl_r;
    logic [7:0] modeCfg_r;
    logic [7:0] corePark_r;
    logic [7:0] avgDepth_r;
    logic [7:0] pinSetup_r;
    logic [7:0] softTrig_r;

    cal_state_t state_r;
    cal_state_t state_nxt;

    logic       fgComplete_r;
    logic       halted_r;
    logic [2:0] statCode_r;
    logic       pin_r;
    logic       runBit;
    logic       bgEnable;
    logic       fgSelect;
    logic       trigger;
    logic       timerLoad;
    logic       timerExpired;
    logic       leaveHeld;
    logic [calib_ctrl_pkg::CNT_W-1:0] sweepLen;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = regWrite && (addr == target);
    endfunction

    // core enables: one parked core when background calibration is off and the code is 0 to 2
    function automatic logic [2:0] park_decode(input logic [1:0] code, input logic bg);
        if (bg) begin
            park_decode = 3'h7;
        end else begin
            unique case (code)
                calib_ctrl_pkg::PARK_CORE0: park_decode = 3'h6;
                calib_ctrl_pkg::PARK_CORE1: park_decode = 3'h5;
                calib_ctrl_pkg::PARK_CORE2: park_decode = 3'h3;
                default:                    park_decode = 3'h7;
            endcase
        end
    endfunction

    // registers hold only their defined bits, the rest are zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            runCtl_r <= calib_ctrl_pkg::RST_RUN_CONTROL; // RL1
        end else if (hit(regAddr, calib_ctrl_pkg::ADDR_RUN_CONTROL)) begin
            runCtl_r <= regWdata & calib_ctrl_pkg::MASK_RUN_CONTROL;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            modeCfg_r <= calib_ctrl_pkg::RST_MODE_CONFIG; // RL7 RL8
        end else if (hit(regAddr, calib_ctrl_pkg::ADDR_MODE_CONFIG)) begin
            modeCfg_r <= regWdata & calib_ctrl_pkg::MASK_MODE_CONFIG;
        end
    end

    // no interlock on the link enable: keeping the field still is software's duty
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            corePark_r <= calib_ctrl_pkg::RST_CORE_PARK; // RL10
        end else if (hit(regAddr, calib_ctrl_pkg::ADDR_CORE_PARK)) begin
            corePark_r <= regWdata & calib_ctrl_pkg::MASK_CORE_PARK;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            avgDepth_r <= calib_ctrl_pkg::RST_AVERAGING; // RL11 RL12
        end else if (hit(regAddr, calib_ctrl_pkg::ADDR_AVERAGING)) begin
            avgDepth_r <= regWdata & calib_ctrl_pkg::MASK_AVERAGING;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pinSetup_r <= calib_ctrl_pkg::RST_PIN_SETUP;
        end else if (hit(regAddr, calib_ctrl_pkg::ADDR_PIN_SETUP)) begin
            pinSetup_r <= regWdata & calib_ctrl_pkg::MASK_PIN_SETUP;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            softTrig_r <= calib_ctrl_pkg::RST_SOFT_TRIGGER;
        end else if (hit(regAddr, calib_ctrl_pkg::ADDR_SOFT_TRIGGER)) begin
            softTrig_r <= regWdata & calib_ctrl_pkg::MASK_SOFT_TRIGGER;
        end
    end

    assign runBit   = runCtl_r[calib_ctrl_pkg::RUN_BIT];
    assign bgEnable = modeCfg_r[calib_ctrl_pkg::BG_ENABLE_BIT];
    assign fgSelect = modeCfg_r[calib_ctrl_pkg::FG_SELECT_BIT];

    // the ignored source has no influence at all
    assign trigger = pinSetup_r[calib_ctrl_pkg::TRIG_SRC_BIT]
                     ? hardware_trigger_input                      // RL18
                     : softTrig_r[0];                              // RL18

    // held in reset whenever run is low; dividers follow the same bit
    assign engineResetN  = runBit;           // RL1
    assign dividerResetN = runBit;           // RL2
    assign calValueClear = (state_r == ST_CLEAR); // RL8

    // plain register view: holding the engine while run is low is the engine reset's job
    always_comb begin
        engineCtl.bgActive       = bgEnable;                                   // RL7
        engineCtl.bgOffsetActive = bgEnable
                                   && modeCfg_r[calib_ctrl_pkg::BG_OFFSET_BIT]; // RL5
        engineCtl.fgOffsetActive = fgSelect
                                   && modeCfg_r[calib_ctrl_pkg::FG_OFFSET_BIT]; // RL6
        engineCtl.coreEnable     = park_decode(corePark_r[1:0], bgEnable); // RL9
        engineCtl.offsetAveragingLevel    =
            avgDepth_r[calib_ctrl_pkg::OFS_AVG_LSB +: 3];                 // RL11
        engineCtl.linearityAveragingLevel =
            avgDepth_r[calib_ctrl_pkg::LIN_AVG_LSB +: 3];                 // RL12
    end

    // deeper linearity averaging lengthens the foreground sweep
    assign sweepLen = CNT_W_CAST(calib_ctrl_pkg::FG_BASE_CYC)
                      << avgDepth_r[calib_ctrl_pkg::LIN_AVG_LSB +: 3];

    function automatic logic [calib_ctrl_pkg::CNT_W-1:0] CNT_W_CAST(input int v);
        CNT_W_CAST = v[calib_ctrl_pkg::CNT_W-1:0];
    endfunction

    assign leaveHeld = runBit && (state_r == ST_HELD);

    always_comb begin
        state_nxt = state_r;
        timerLoad = 1'b0;
        unique case (state_r)
            ST_HELD: begin
                if (runBit) begin
                    state_nxt = ST_CLEAR; // RL8
                    timerLoad = 1'b1;
                end
            end
            ST_CLEAR: begin
                if (timerExpired) begin
                    state_nxt = ST_WAIT_TRIG;
                end
            end
            ST_WAIT_TRIG: begin
                if (trigger) begin
                    if (fgSelect) begin
                        state_nxt = ST_FG_RUN; // RL8
                        timerLoad = 1'b1;
                    end else begin
                        state_nxt = bgEnable ? ST_BG_RUN : ST_IDLE;
                    end
                end
            end
            ST_FG_RUN: begin
                if (timerExpired) begin
                    state_nxt = bgEnable ? ST_BG_RUN : ST_IDLE;
                end
            end
            ST_BG_RUN: begin
                if (!bgEnable) begin
                    state_nxt = ST_IDLE; // RL7
                end
            end
            ST_IDLE: begin
                if (bgEnable) begin
                    state_nxt = ST_BG_RUN;
                end
            end
        endcase
        if (!runBit) begin
            state_nxt = ST_HELD; // RL1
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_HELD;
        end else begin
            state_r <= state_nxt;
        end
    end

    calib_seq_timer u_timer (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .load      (timerLoad),
        .loadValue (leaveHeld ? CNT_W_CAST(calib_ctrl_pkg::CLEAR_CYC) : sweepLen),
        .abort     (!runBit),
        .busy      (),
        .expired   (timerExpired)
    );

    // foreground finished or skipped
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fgComplete_r <= 1'b0;
        end else if (!runBit || state_r == ST_HELD || state_r == ST_CLEAR) begin
            fgComplete_r <= 1'b0; // RL19
        end else if (state_nxt == ST_BG_RUN || state_nxt == ST_IDLE) begin
            fgComplete_r <= 1'b1; // RL16
        end
    end

    // halted: stopped on request, or no background once foreground is over
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            halted_r <= 1'b0;
        end else if (!runBit || state_r == ST_HELD || state_r == ST_CLEAR) begin
            halted_r <= 1'b0; // RL19
        end else if (state_nxt == ST_IDLE) begin
            halted_r <= 1'b1; // RL15
        end else if (state_r == ST_BG_RUN) begin
            halted_r <= bgStopRequest; // RL14
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            statCode_r <= calib_ctrl_pkg::STAT_HELD;
        end else begin
            unique case (state_nxt)
                ST_HELD:      statCode_r <= calib_ctrl_pkg::STAT_HELD; // RL13
                ST_CLEAR:     statCode_r <= calib_ctrl_pkg::STAT_CLEARING;
                ST_WAIT_TRIG: statCode_r <= calib_ctrl_pkg::STAT_WAIT_TRG;
                ST_FG_RUN:    statCode_r <= calib_ctrl_pkg::STAT_FG_RUN;
                ST_BG_RUN:    statCode_r <= calib_ctrl_pkg::STAT_BG_RUN;
                ST_IDLE:      statCode_r <= calib_ctrl_pkg::STAT_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_r <= 1'b0;
        end else begin
            unique case (pinSetup_r[calib_ctrl_pkg::PIN_SEL_LSB +: 2])
                calib_ctrl_pkg::PIN_SEL_FG_COMPLETE: pin_r <= fgComplete_r; // RL17
                calib_ctrl_pkg::PIN_SEL_HALTED:      pin_r <= halted_r;     // RL17
                calib_ctrl_pkg::PIN_SEL_ALARM:       pin_r <= alarm;        // RL17
                default:                             pin_r <= 1'b0;         // RL17
            endcase
        end
    end

    assign status_output_pin = pin_r;

    always_comb begin
        regRdata = 8'h00;
        if (regRead) begin
            unique case (regAddr)
                calib_ctrl_pkg::ADDR_RUN_CONTROL:  regRdata = runCtl_r;
                calib_ctrl_pkg::ADDR_MODE_CONFIG:  regRdata = modeCfg_r;
                calib_ctrl_pkg::ADDR_CORE_PARK:    regRdata = corePark_r;
                calib_ctrl_pkg::ADDR_AVERAGING:    regRdata = avgDepth_r;
                calib_ctrl_pkg::ADDR_STATUS_FLAGS:
                    regRdata = {3'h0, statCode_r, halted_r, fgComplete_r}; // RL13
                calib_ctrl_pkg::ADDR_PIN_SETUP:    regRdata = pinSetup_r;
                calib_ctrl_pkg::ADDR_SOFT_TRIGGER: regRdata = softTrig_r;
                default:                           regRdata = 8'h00;
            endcase
        end
    end

    // software ordering against the link enable is not enforced here
    // RL3 RL4: relied on; the divider reset is simply tied to the run bit
endmodule
`default_nettype wire

// ===== src/calib_ctrl_pkg.sv
// package: register map, field positions, reset values and timing for calibration control
package calib_ctrl_pkg;

    localparam logic [7:0] ADDR_RUN_CONTROL  = 8'h61;
    localparam logic [7:0] ADDR_MODE_CONFIG  = 8'h62;
    localparam logic [7:0] ADDR_CORE_PARK    = 8'h64;
    localparam logic [7:0] ADDR_AVERAGING    = 8'h68;
    localparam logic [7:0] ADDR_STATUS_FLAGS = 8'h6A;
    localparam logic [7:0] ADDR_PIN_SETUP    = 8'h6B;
    localparam logic [7:0] ADDR_SOFT_TRIGGER = 8'h6C;

    localparam logic [7:0] RST_RUN_CONTROL   = 8'h01;
    localparam logic [7:0] RST_MODE_CONFIG   = 8'h01;
    localparam logic [7:0] RST_CORE_PARK     = 8'h02;
    localparam logic [7:0] RST_AVERAGING     = 8'h61;
    localparam logic [7:0] RST_PIN_SETUP     = 8'h00;
    localparam logic [7:0] RST_SOFT_TRIGGER  = 8'h01;

    // writable bits per register; the rest read as zero
    localparam logic [7:0] MASK_RUN_CONTROL  = 8'h01;
    localparam logic [7:0] MASK_MODE_CONFIG  = 8'h0F;
    localparam logic [7:0] MASK_CORE_PARK    = 8'h03;
    localparam logic [7:0] MASK_AVERAGING    = 8'h77;
    localparam logic [7:0] MASK_PIN_SETUP    = 8'h07;
    localparam logic [7:0] MASK_SOFT_TRIGGER = 8'h01;

    localparam int RUN_BIT        = 0;
    localparam int FG_SELECT_BIT  = 0;
    localparam int BG_ENABLE_BIT  = 1;
    localparam int FG_OFFSET_BIT  = 2;
    localparam int BG_OFFSET_BIT  = 3;
    localparam int PARK_LSB       = 0;
    localparam int LIN_AVG_LSB    = 0;
    localparam int OFS_AVG_LSB    = 4;
    localparam int FG_COMPLETE_BIT = 0;
    localparam int HALTED_BIT     = 1;
    localparam int STAT_CODE_LSB  = 2;
    localparam int TRIG_SRC_BIT   = 0;
    localparam int PIN_SEL_LSB    = 1;

    localparam logic [1:0] PIN_SEL_FG_COMPLETE = 2'h0;
    localparam logic [1:0] PIN_SEL_HALTED  = 2'h1;
    localparam logic [1:0] PIN_SEL_ALARM   = 2'h2;

    localparam logic [1:0] PARK_CORE0 = 2'h0;
    localparam logic [1:0] PARK_CORE1 = 2'h1;
    localparam logic [1:0] PARK_CORE2 = 2'h2;

    // status codes reported in the status field
    localparam logic [2:0] STAT_HELD     = 3'h0;
    localparam logic [2:0] STAT_CLEARING = 3'h1;
    localparam logic [2:0] STAT_FG_RUN   = 3'h2;
    localparam logic [2:0] STAT_BG_RUN   = 3'h3;
    localparam logic [2:0] STAT_IDLE     = 3'h4;
    localparam logic [2:0] STAT_WAIT_TRG = 3'h5;

    // foreground sweep length: base time doubled for each step of the linearity averaging code
    localparam int CLK_MHZ       = 25;
    localparam int FG_BASE_NS    = 640;
    localparam int FG_BASE_CYC   = (FG_BASE_NS * CLK_MHZ) / 1000;
    localparam int CLEAR_CYC     = 4;
    localparam int CNT_W         = 12;

    typedef enum logic [1:0] {
        TRIG_SOFTWARE = 2'h0,
        TRIG_HARDWARE = 2'h1
    } trig_src_t;

    typedef struct packed {
        logic       fgOffsetActive;
        logic       bgOffsetActive;
        logic       bgActive;
        logic [2:0] coreEnable;
        logic [2:0] offsetAveragingLevel;
        logic [2:0] linearityAveragingLevel;
    } engine_ctl_t;

endpackage

// ===== src/calib_seq_timer.sv
// sweep timer: loads a cycle count and pulses when it expires
`timescale 1ns/10ps
`default_nettype none
module calib_seq_timer (
    // clock and reset
    input  wire logic                              sys_clk,
    input  wire logic                              rst,
    // control
    input  wire logic                              load,
    input  wire logic [calib_ctrl_pkg::CNT_W-1:0]  loadValue,
    input  wire logic                              abort,
    // status
    output logic                                   busy,
    output logic                                   expired
);
    logic [calib_ctrl_pkg::CNT_W-1:0] count_r;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count_r <= '0;
        end else if (abort) begin
            count_r <= '0;
        end else if (load) begin
            count_r <= loadValue;
        end else if (count_r != '0) begin
            count_r <= count_r - 1'b1;
        end
    end

    // marks the last counted cycle, so the caller leaves after exactly loadValue cycles
    assign expired = !abort && !load
                     && (count_r == {{(calib_ctrl_pkg::CNT_W-1){1'b0}}, 1'b1});

    assign busy = (count_r != '0);
endmodule
`default_nettype wire

// ===== tb/calib_ctrl_assertions.sv
// checker: port relations of the calibration control block
`timescale 1ns/10ps
`default_nettype none
module calib_ctrl_assertions (
    // clock and reset
    input wire logic                        sys_clk,
    input wire logic                        rst,
    // register port
    input wire logic                        regWrite,
    input wire logic                        regRead,
    input wire logic [7:0]                  regAddr,
    input wire logic [7:0]                  regWdata,
    input wire logic [7:0]                  regRdata,
    // engine side
    input wire logic                        engineResetN,
    input wire logic                        dividerResetN,
    input wire logic                        calValueClear,
    input wire calib_ctrl_pkg::engine_ctl_t engineCtl
);
    logic wrRun;
    logic wrMode;
    logic wrPark;
    logic wrAvg;
    logic rdStat;
    assign wrRun  = regWrite && regAddr == calib_ctrl_pkg::ADDR_RUN_CONTROL;
    assign wrMode = regWrite && regAddr == calib_ctrl_pkg::ADDR_MODE_CONFIG;
    assign wrPark = regWrite && regAddr == calib_ctrl_pkg::ADDR_CORE_PARK;
    assign wrAvg  = regWrite && regAddr == calib_ctrl_pkg::ADDR_AVERAGING;
    assign rdStat = regRead && regAddr == calib_ctrl_pkg::ADDR_STATUS_FLAGS;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    run_follow_a: assert property (wrRun |=> engineResetN == $past(regWdata[0]))
        else $error("engine reset does not follow run bit");
    divider_tie_a: assert property (wrRun |=> dividerResetN == $past(regWdata[0]))
        else $error("divider reset differs from run state");
    clear_start_a: assert property ($rose(engineResetN) |-> ##[1:2] calValueClear)
        else $error("no value clear after run set");
    clear_len_a: assert property ($rose(calValueClear) |-> calValueClear[*4] ##1 !calValueClear)
        else $error("value clear not four cycles");
    mode_map_a: assert property (wrMode |=> engineCtl.bgActive == $past(regWdata[1])
        && engineCtl.bgOffsetActive == $past(regWdata[3] & regWdata[1])
        && engineCtl.fgOffsetActive == $past(regWdata[2] & regWdata[0]))
        else $error("mode controls wrong after write");
    avg_map_a: assert property (wrAvg |=> engineCtl.offsetAveragingLevel == $past(regWdata[6:4])
        && engineCtl.linearityAveragingLevel == $past(regWdata[2:0]))
        else $error("averaging levels wrong after write");
    park_core_a: assert property (wrPark && regWdata[1:0] != 2'h3 && !engineCtl.bgActive
        |=> !engineCtl.coreEnable[$past(regWdata[1:0])])
        else $error("parked core still enabled");
    stat_rsvd_a: assert property (rdStat |-> regRdata[7:5] == 3'h0)
        else $error("status reserved bits not zero");
    flags_held_a: assert property (rdStat && !engineResetN && !$past(engineResetN)
        |-> regRdata[1:0] == 2'h0)
        else $error("flags set while held");
    clear_flags_a: assert property (rdStat && calValueClear |-> regRdata[1:0] == 2'h0)
        else $error("flags set during value clear");
endmodule

bind adc_calibration_control calib_ctrl_assertions i_chk (
    .sys_clk(sys_clk), .rst(rst), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .engineResetN(engineResetN), .dividerResetN(dividerResetN),
    .calValueClear(calValueClear), .engineCtl(engineCtl)
);
`default_nettype wire

// ===== tb/adc_calibration_control_test.sv
// self-checking bench for the calibration control block
`timescale 1ns/10ps
`default_nettype none
module adc_calibration_control_test;
    logic                        sys_clk = 1'b0;
    logic                        rst = 1'b1;
    logic                        regWrite = 1'b0;
    logic                        regRead = 1'b0;
    logic [7:0]                  regAddr = 8'h00;
    logic [7:0]                  regWdata = 8'h00;
    logic [7:0]                  regRdata;
    logic                        linkEnable = 1'b0;
    logic                        hwTrigger = 1'b0;
    logic                        alarm = 1'b0;
    logic                        bgStop = 1'b0;
    logic                        engineResetN;
    logic                        dividerResetN;
    logic                        calValueClear;
    logic                        statusPin;
    calib_ctrl_pkg::engine_ctl_t engineCtl;
    logic [7:0]                  rd;
    int                          n_errors = 0;
    int                          compares = 0;

    always #20 sys_clk = ~sys_clk;

    adc_calibration_control i_dut (
        .sys_clk(sys_clk), .rst(rst), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .serial_link_enable(linkEnable), .hardware_trigger_input(hwTrigger),
        .alarm(alarm), .bgStopRequest(bgStop), .engineResetN(engineResetN),
        .dividerResetN(dividerResetN), .calValueClear(calValueClear),
        .engineCtl(engineCtl), .status_output_pin(statusPin)
    );

    task automatic end_of_test();
        if (n_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        regWrite = 1'b1;
        regAddr = a;
        regWdata = d;
        @(negedge sys_clk);
        regWrite = 1'b0;
    endtask

    // read data is sampled 5 ns into the low phase, away from register updates
    task automatic rdr(input logic [7:0] a);
        @(negedge sys_clk);
        regRead = 1'b1;
        regAddr = a;
        #5;
        rd = regRdata;
        @(negedge sys_clk);
        regRead = 1'b0;
    endtask

    task automatic rcheck(input logic [7:0] a, input logic [7:0] exp, input string what);
        rdr(a);
        check(what, exp, rd);
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic wait_stat(input logic [7:0] mask, input logic [7:0] val);
        int n;
        n = 0;
        rdr(8'h6A);
        while ((rd & mask) !== val) begin
            n++;
            if (n > 200) begin
                n_errors++;
                $display("Error status wait expected %h seen %h", val, rd & mask);
                end_of_test();
            end
            rdr(8'h6A);
        end
    endtask

    task automatic reset_values();
        check("engineResetN", 8'h01, 8'(engineResetN));
        rcheck(8'h61, 8'h01, "run");
        rcheck(8'h62, 8'h01, "mode");
        rcheck(8'h64, 8'h02, "park");
        rcheck(8'h68, 8'h61, "avg");
        rcheck(8'h6B, 8'h00, "pinsetup");
        rcheck(8'h6C, 8'h01, "softtrig");
        rcheck(8'h70, 8'h00, "unmapped");
    endtask

    task automatic default_sweep();
        wait_stat(8'h03, 8'h03);
        rcheck(8'h6A, {3'h0, calib_ctrl_pkg::STAT_IDLE, 2'h3}, "status");
        for (int i = 0; i < 4; i++) begin
            alarm = i[1];
            wr(8'h6B, 8'(i * 2));
            idle(3);
            check("pin", 8'(i != 3), 8'(statusPin));
        end
        alarm = 1'b0;
        wr(8'h6B, 8'h04);
        idle(3);
        check("pinalarm", 8'h00, 8'(statusPin));
        wr(8'h6B, 8'h00);
        linkEnable = 1'b1;
    endtask

    task automatic hold_and_bg();
        linkEnable = 1'b0;
        wr(8'h61, 8'h00);
        check("engineResetN", 8'h00, 8'(engineResetN));
        check("dividerResetN", 8'h00, 8'(dividerResetN));
        rcheck(8'h6A, {3'h0, calib_ctrl_pkg::STAT_HELD, 2'h0}, "held");
        wr(8'h6A, 8'hFF);
        rcheck(8'h6A, {3'h0, calib_ctrl_pkg::STAT_HELD, 2'h0}, "rostatus");
        wr(8'h62, 8'h0E);
        check("modectl", 8'h03, 8'({engineCtl.fgOffsetActive, engineCtl.bgOffsetActive,
            engineCtl.bgActive}));
        wr(8'h61, 8'h01);
        linkEnable = 1'b1;
        wait_stat(8'h1F, {3'h0, calib_ctrl_pkg::STAT_BG_RUN, 2'h1});
        bgStop = 1'b1;
        wait_stat(8'h03, 8'h03);
        bgStop = 1'b0;
        wait_stat(8'h03, 8'h01);
    endtask

    task automatic park_avg();
        logic [2:0] cores [4] = '{3'h6, 3'h5, 3'h3, 3'h7};
        linkEnable = 1'b0;
        wr(8'h61, 8'h00);
        wr(8'h62, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(8'h64, 8'(i));
            check("cores", 8'(cores[i]), 8'(engineCtl.coreEnable));
        end
        wr(8'h68, 8'hFF);
        rcheck(8'h68, 8'h77, "avgmask");
        wr(8'h68, 8'h35);
        check("avgctl", 8'h35, {1'b0, engineCtl.offsetAveragingLevel, 1'b0,
            engineCtl.linearityAveragingLevel});
        wr(8'h62, 8'h0D);
        check("offsets", 8'h04, 8'({engineCtl.fgOffsetActive, engineCtl.bgOffsetActive,
            engineCtl.bgActive}));
        wr(8'h64, 8'h02);
        wr(8'h68, 8'h61);
    endtask

    task automatic trig_select();
        wr(8'h62, 8'h01);
        wr(8'h6B, 8'h01);
        wr(8'h61, 8'h01);
        idle(20);
        rcheck(8'h6A, {3'h0, calib_ctrl_pkg::STAT_WAIT_TRG, 2'h0}, "hwwait");
        hwTrigger = 1'b1;
        wait_stat(8'h03, 8'h03);
        wr(8'h61, 8'h00);
        wr(8'h6B, 8'h00);
        wr(8'h6C, 8'h00);
        wr(8'h61, 8'h01);
        idle(20);
        rcheck(8'h6A, {3'h0, calib_ctrl_pkg::STAT_WAIT_TRG, 2'h0}, "swwait");
        wr(8'h6C, 8'h01);
        wait_stat(8'h03, 8'h03);
    endtask

    initial begin
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        reset_values();
        default_sweep();
        hold_and_bg();
        park_avg();
        trig_select();
        end_of_test();
    end
endmodule
`default_nettype wire
